// *** hw/pist_pkg.sv ***
// Package for the interrupt summary tree: register map, field positions, types
package pist_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_MON_MASK = 8'h59;
  localparam logic [7:0] IDX_TOP_SUM = 8'h5a;
  localparam logic [7:0] IDX_REG_SUM = 8'h5b;
  localparam logic [7:0] IDX_REG12_EV = 8'h5c;
  localparam logic [7:0] IDX_REG34_EV = 8'h5d;
  localparam logic [7:0] IDX_MON_STAT = 8'h60;

  // ==========================================================================
  // Address decode
  localparam int ADDR_IDX_LSB = 2;
  localparam int ADDR_IDX_MSB = 9;

  // ==========================================================================
  // Field positions
  localparam int MON_RST_BIT = 5;
  localparam int MON_FAIL_BIT = 4;
  localparam int MON_PIN_BIT = 3;
  localparam logic [7:0] MON_USED = 8'h38;
  localparam int REG_SUM_34_BIT = 1;
  localparam int REG_SUM_12_BIT = 0;
  localparam logic [7:0] REG_SUM_USED = 8'h03;
  localparam int TOP_REG_BIT = 0;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // ==========================================================================
  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'h0;

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic state_machine_error;
    logic severe_fault;
    logic moderate_fault;
    logic misc_event;
    logic power_up;
    logic gpio_event;
    logic voltage_monitor;
  } pist_leaf_pending_t;

  typedef struct packed {
    logic proc_reset_monitor_event;
    logic proc_failure_monitor_event;
    logic monitor_pin_error_event;
  } pist_mon_event_t;

  typedef struct packed {
    logic [7:0] regulators_three_four;
    logic [7:0] regulators_one_two;
  } pist_reg_event_t;

endpackage

// *** hw/pist_summary_tree.sv ***
// Interrupt summary tree with monitor mask, regulator leaf events and AHB-Lite slave
//
// Function
// - Monitor mask bit 5 set to one suppresses the processor-reset monitor interrupt, zero lets it through.
// - Monitor mask bit 4 set to one suppresses the processor-failure monitor interrupt, zero lets it through.
// - Monitor mask bit 3 set to one suppresses the monitor-pin error interrupt, zero lets it through.
// - The monitor mask bits take their start value from nonvolatile memory; bits 7:6 and 2:0 are plain RW, reset zero.
// - Top summary bit 7 is one while the state-machine error register holds any set bit and clears itself after.
// - Top summary bit 6 is one while the severe error register holds any set bit and clears itself after.
// - Top summary bit 5 is one while the moderate error register holds any set bit and clears itself after.
// - Top summary bit 4 is one while the miscellaneous event register holds any set bit and clears itself after.
// - Top summary bit 3 is one while the startup event register holds any set bit and clears itself after.
// - Top summary bit 2 is one while the pin event register holds any set bit and clears itself after.
// - Top summary bit 1 is one while the voltage monitor register holds any set bit and clears itself after.
// - Top summary bit 0 is one while the regulator summary register is nonzero and clears itself after.
// - Regulator summary bit 1 is one while the third-and-fourth regulator register is nonzero.
// - Regulator summary bit 0 is one while the first-and-second regulator register is nonzero.
// - Summary registers are read-only, reset to zero, and regulator summary bits 7:2 read as zero.
// - Regulator event bits latch on their event and stay set until a one is written to them.
`timescale 1ns/1ns
`default_nettype none

module pist_summary_tree (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_B,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Nonvolatile defaults
  input wire logic NVM_LOAD,
  input wire logic [7:0] NVM_MON_MASK,
  // Event sources
  input wire pist_pkg::pist_mon_event_t MON_EVENT,
  input wire pist_pkg::pist_reg_event_t REG_EVENT,
  input wire pist_pkg::pist_leaf_pending_t LEAF_PENDING,
  // Interrupt
  output logic IRQ
);

  // ==========================================================================
  // Register state
  logic [7:0] mon_mask;
  logic [7:0] mon_status;
  logic [7:0] reg12_events;
  logic [7:0] reg34_events;
  logic [7:0] reg_summary;
  logic [7:0] top_summary;
  logic [7:0] next_mon_mask;
  logic [7:0] next_mon_status;
  logic [7:0] next_reg12_events;
  logic [7:0] next_reg34_events;
  logic [7:0] next_reg_summary;
  logic [7:0] next_top_summary;

  // ==========================================================================
  // Bus phases
  logic wr_pend;
  logic [7:0] wr_idx;
  logic addr_valid;
  logic [7:0] addr_idx;
  logic [7:0] wr_byte;

  function automatic logic hit(input logic [7:0] idx, input logic [7:0] reg_idx, input logic en);
    hit = en && (idx == reg_idx);
  endfunction

  function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] set, input logic clr_en,
                                     input logic [7:0] data);
    // A set arriving with the clear survives it
    w1c = (cur & ~(clr_en ? data : pist_pkg::RST_BYTE)) | set;
  endfunction

  assign addr_valid = HSEL && HTRANS[pist_pkg::HTRANS_ACTIVE_BIT] && HREADY;
  assign addr_idx = HADDR[pist_pkg::ADDR_IDX_MSB:pist_pkg::ADDR_IDX_LSB];
  assign wr_byte = HWDATA[7:0];

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      wr_pend <= 1'b0;
      wr_idx <= pist_pkg::RST_BYTE;
    end else if (HREADY) begin
      wr_pend <= addr_valid && HWRITE;
      wr_idx <= addr_idx;
    end
  end

  // ==========================================================================
  // Next values
  always_comb begin
    next_mon_mask = mon_mask;
    if (hit(wr_idx, pist_pkg::IDX_MON_MASK, wr_pend)) begin
      next_mon_mask = wr_byte;
    end else if (NVM_LOAD) begin
      next_mon_mask = (mon_mask & ~pist_pkg::MON_USED) | (NVM_MON_MASK & pist_pkg::MON_USED);
    end
  end

  always_comb begin
    logic [7:0] mon_set;
    mon_set = pist_pkg::RST_BYTE;
    mon_set[pist_pkg::MON_RST_BIT] = MON_EVENT.proc_reset_monitor_event;
    mon_set[pist_pkg::MON_FAIL_BIT] = MON_EVENT.proc_failure_monitor_event;
    mon_set[pist_pkg::MON_PIN_BIT] = MON_EVENT.monitor_pin_error_event;
    next_mon_status = w1c(mon_status, mon_set, hit(wr_idx, pist_pkg::IDX_MON_STAT, wr_pend), wr_byte);
  end

  always_comb begin
    next_reg12_events = w1c(reg12_events, REG_EVENT.regulators_one_two,
                            hit(wr_idx, pist_pkg::IDX_REG12_EV, wr_pend), wr_byte);
    next_reg34_events = w1c(reg34_events, REG_EVENT.regulators_three_four,
                            hit(wr_idx, pist_pkg::IDX_REG34_EV, wr_pend), wr_byte);
  end

  always_comb begin
    next_reg_summary = pist_pkg::RST_BYTE;
    next_reg_summary[pist_pkg::REG_SUM_34_BIT] = |next_reg34_events;
    next_reg_summary[pist_pkg::REG_SUM_12_BIT] = |next_reg12_events;
    next_top_summary = {LEAF_PENDING.state_machine_error,
                        LEAF_PENDING.severe_fault,
                        LEAF_PENDING.moderate_fault,
                        LEAF_PENDING.misc_event,
                        LEAF_PENDING.power_up,
                        LEAF_PENDING.gpio_event,
                        LEAF_PENDING.voltage_monitor,
                        |next_reg_summary};
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      mon_mask <= pist_pkg::RST_BYTE;
    end else begin
      mon_mask <= next_mon_mask;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      mon_status <= pist_pkg::RST_BYTE;
      reg12_events <= pist_pkg::RST_BYTE;
      reg34_events <= pist_pkg::RST_BYTE;
    end else begin
      mon_status <= next_mon_status;
      reg12_events <= next_reg12_events;
      reg34_events <= next_reg34_events;
    end
  end

  // Summaries are read-only mirrors of their sources
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      reg_summary <= pist_pkg::RST_BYTE;
      top_summary <= pist_pkg::RST_BYTE;
    end else begin
      reg_summary <= next_reg_summary;
      top_summary <= next_top_summary;
    end
  end

  // ==========================================================================
  // Interrupt output
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= (|(next_mon_status & ~next_mon_mask & pist_pkg::MON_USED)) || (|next_top_summary);
    end
  end

  // ==========================================================================
  // Read data: taken from next values so a read right after a write sees it
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      HRDATA <= pist_pkg::RST_WORD;
    end else if (addr_valid && !HWRITE) begin
      unique case (addr_idx)
        pist_pkg::IDX_MON_MASK: HRDATA <= {24'h00_0000, next_mon_mask};
        pist_pkg::IDX_TOP_SUM: HRDATA <= {24'h00_0000, next_top_summary};
        pist_pkg::IDX_REG_SUM: HRDATA <= {24'h00_0000, next_reg_summary};
        pist_pkg::IDX_REG12_EV: HRDATA <= {24'h00_0000, next_reg12_events};
        pist_pkg::IDX_REG34_EV: HRDATA <= {24'h00_0000, next_reg34_events};
        pist_pkg::IDX_MON_STAT: HRDATA <= {24'h00_0000, next_mon_status};
        default: HRDATA <= pist_pkg::RST_WORD;
      endcase
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      HREADYOUT <= 1'b1;
      HRESP <= pist_pkg::HRESP_OKAY;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= pist_pkg::HRESP_OKAY;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_B);

  chk_rst_mask_gate: assert property (
    (mon_status[pist_pkg::MON_RST_BIT] && mon_mask[pist_pkg::MON_RST_BIT] && !(|top_summary)
      && !(|(mon_status & ~mon_mask & pist_pkg::MON_USED))) |-> !IRQ)
    else $error("masked reset monitor event raised the interrupt");

  chk_fail_mask_gate: assert property (
    (mon_status[pist_pkg::MON_FAIL_BIT] && !mon_mask[pist_pkg::MON_FAIL_BIT]) |-> IRQ)
    else $error("unmasked failure monitor event did not raise the interrupt");

  chk_pin_mask_gate: assert property (
    (mon_status[pist_pkg::MON_PIN_BIT] && !mon_mask[pist_pkg::MON_PIN_BIT]) |-> IRQ)
    else $error("unmasked pin monitor event did not raise the interrupt");

  chk_rst_unmask_gate: assert property (
    (mon_status[pist_pkg::MON_RST_BIT] && !mon_mask[pist_pkg::MON_RST_BIT])
      |-> IRQ)
    else $error("unmasked reset monitor event did not raise the interrupt");

  chk_fail_masked_gate: assert property (
    (mon_status[pist_pkg::MON_FAIL_BIT] && mon_mask[pist_pkg::MON_FAIL_BIT] && !(|top_summary)
      && !(|(mon_status & ~mon_mask & pist_pkg::MON_USED))) |-> !IRQ)
    else $error("masked failure monitor event raised the interrupt");

  chk_pin_masked_gate: assert property (
    (mon_status[pist_pkg::MON_PIN_BIT] && mon_mask[pist_pkg::MON_PIN_BIT] && !(|top_summary)
      && !(|(mon_status & ~mon_mask & pist_pkg::MON_USED))) |-> !IRQ)
    else $error("masked pin monitor event raised the interrupt");

  chk_mask_write: assert property (
    hit(wr_idx, pist_pkg::IDX_MON_MASK, wr_pend)
      |=> mon_mask == $past(wr_byte))
    else $error("mask write did not land");

  chk_mask_hold: assert property (
    (!NVM_LOAD && !hit(wr_idx, pist_pkg::IDX_MON_MASK, wr_pend))
      |=> mon_mask == $past(mon_mask))
    else $error("mask changed without a write or load");

  chk_fsm_selfclear: assert property (
    !LEAF_PENDING.state_machine_error
      |=> !top_summary[7])
    else $error("state machine error summary did not clear");

  chk_sev_summary: assert property (
    LEAF_PENDING.severe_fault
      |=> top_summary[6])
    else $error("severe fault summary not set");

  chk_mod_summary: assert property (
    LEAF_PENDING.moderate_fault
      |=> top_summary[5])
    else $error("moderate fault summary not set");

  chk_misc_summary: assert property (
    LEAF_PENDING.misc_event
      |=> top_summary[4])
    else $error("miscellaneous event summary not set");

  chk_pwr_summary: assert property (
    LEAF_PENDING.power_up
      |=> top_summary[3])
    else $error("power up event summary not set");

  chk_gpio_summary: assert property (
    LEAF_PENDING.gpio_event
      |=> top_summary[2])
    else $error("pin event summary not set");

  chk_vmon_summary: assert property (
    LEAF_PENDING.voltage_monitor
      |=> top_summary[1])
    else $error("voltage monitor summary not set");

  chk_reg_top_set: assert property (
    (|reg_summary)
      |-> top_summary[pist_pkg::TOP_REG_BIT])
    else $error("regulator top summary bit not set");

  chk_reg12_summary: assert property (
    reg_summary[pist_pkg::REG_SUM_12_BIT]
      == (|reg12_events))
    else $error("first regulator pair summary wrong");

  chk_reg34_summary: assert property (
    reg_summary[pist_pkg::REG_SUM_34_BIT]
      == (|reg34_events))
    else $error("second regulator pair summary wrong");

  chk_reg34_latch: assert property (
    (|REG_EVENT.regulators_three_four)
      |=> (reg34_events & $past(REG_EVENT.regulators_three_four)) == $past(REG_EVENT.regulators_three_four))
    else $error("second regulator pair event lost");

  chk_reg12_set_wins: assert property (
    (|REG_EVENT.regulators_one_two)
      |=> (reg12_events & $past(REG_EVENT.regulators_one_two)) == $past(REG_EVENT.regulators_one_two))
    else $error("first regulator pair event lost");

  chk_rdata_upper: assert property (
    HRDATA[31:8]
      == 24'h00_0000)
    else $error("read data upper bits nonzero");

  chk_nvm_mask_load: assert property (
    (NVM_LOAD && !(wr_pend && wr_idx == pist_pkg::IDX_MON_MASK))
      |=> ((mon_mask & pist_pkg::MON_USED) == ($past(NVM_MON_MASK) & pist_pkg::MON_USED))
        && ((mon_mask & ~pist_pkg::MON_USED) == ($past(mon_mask) & ~pist_pkg::MON_USED)))
    else $error("mask load from nonvolatile memory went wrong");

  chk_fsm_summary: assert property (
    LEAF_PENDING.state_machine_error |=> top_summary[7])
    else $error("state machine error summary not set");

  chk_leaf_follow: assert property (
    ##1 top_summary[7:1] == $past(LEAF_PENDING))
    else $error("top summary does not follow leaf pending levels");

  chk_top_selfclear: assert property (
    (reg12_events == pist_pkg::RST_BYTE && reg34_events == pist_pkg::RST_BYTE)
      |-> !top_summary[pist_pkg::TOP_REG_BIT])
    else $error("regulator top summary bit stuck after clear");

  chk_reg_summary: assert property (
    reg_summary == {6'h00, |reg34_events, |reg12_events})
    else $error("regulator summary does not match its sources");

  chk_reserved_zero: assert property (
    (reg_summary & ~pist_pkg::REG_SUM_USED) == pist_pkg::RST_BYTE)
    else $error("regulator summary reserved bits nonzero");

  chk_event_latch: assert property (
    (|REG_EVENT.regulators_one_two) |=> ((reg12_events & $past(REG_EVENT.regulators_one_two))
      == $past(REG_EVENT.regulators_one_two)) [*2] or !(wr_pend))
    else $error("regulator event lost");

  chk_w1c_clear: assert property (
    (wr_pend && HREADY && wr_idx == pist_pkg::IDX_REG12_EV && REG_EVENT.regulators_one_two == pist_pkg::RST_BYTE)
      |=> (reg12_events & $past(wr_byte)) == pist_pkg::RST_BYTE)
    else $error("write one did not clear regulator event");

  chk_bus_okay: assert property (
    HREADYOUT && HRESP == pist_pkg::HRESP_OKAY)
    else $error("slave answer not ready and okay");

endmodule

`default_nettype wire

// *** tb/pist_summary_tree_tb.sv ***
// Self-checking testbench for the interrupt summary tree
`timescale 1ns/1ns
`default_nettype none

module pist_summary_tree_tb;
  // ==========================================================================
  // Signals
  logic CLOCK = 1'b0;
  logic RST_B = 1'b0;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HWDATA = 32'h0;
  wire logic HREADY;
  logic [31:0] HRDATA;
  logic HREADYOUT;
  logic HRESP;
  logic NVM_LOAD = 1'b0;
  logic [7:0] NVM_MON_MASK = 8'h00;
  pist_pkg::pist_mon_event_t MON_EVENT = '0;
  pist_pkg::pist_reg_event_t REG_EVENT = '0;
  pist_pkg::pist_leaf_pending_t LEAF_PENDING = '0;
  logic IRQ;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;

  assign HREADY = HREADYOUT;
  always #5 CLOCK = ~CLOCK;

  pist_summary_tree pist_summary_tree_inst (
    .CLOCK(CLOCK), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .NVM_LOAD(NVM_LOAD), .NVM_MON_MASK(NVM_MON_MASK),
    .MON_EVENT(MON_EVENT), .REG_EVENT(REG_EVENT), .LEAF_PENDING(LEAF_PENDING), .IRQ(IRQ)
  );

  // ==========================================================================
  // Reporting
  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  always @(posedge CLOCK) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      give_verdict();
    end
  end

  // ==========================================================================
  // AHB-Lite master
  function automatic logic [31:0] addr(input logic [7:0] idx);
    return {22'h0, idx, 2'h0};
  endfunction

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] q);
    @(posedge CLOCK);
    HSEL <= 1'b1;
    HADDR <= addr(idx);
    HTRANS <= 2'h2;
    HWRITE <= wr;
    do @(posedge CLOCK); while (HREADY !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= pist_pkg::HTRANS_IDLE;
    HWDATA <= wr ? d : 32'h0;
    do @(posedge CLOCK); while (HREADY !== 1'b1);
    q = HRDATA;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 32'h0, q);
    check(name, q, exp);
  endtask

  task automatic irq_chk(input logic exp);
    check("irq", {31'h0, IRQ}, {31'h0, exp});
  endtask

  // ==========================================================================
  // Tests
  initial begin
    repeat (6) @(posedge CLOCK);
    RST_B <= 1'b1;
    // Reset values and unmapped address
    rd_chk("mask", pist_pkg::IDX_MON_MASK, 32'h0);
    rd_chk("top", pist_pkg::IDX_TOP_SUM, 32'h0);
    rd_chk("regsum", pist_pkg::IDX_REG_SUM, 32'h0);
    rd_chk("reg12", pist_pkg::IDX_REG12_EV, 32'h0);
    rd_chk("reg34", pist_pkg::IDX_REG34_EV, 32'h0);
    rd_chk("monstat", pist_pkg::IDX_MON_STAT, 32'h0);
    rd_chk("unmapped", 8'hff, 32'h0);
    check("hresp", {31'h0, HRESP}, 32'h0);
    check("hreadyout", {31'h0, HREADYOUT}, 32'h1);
    irq_chk(1'b0);
    // Mask read-write, summaries read-only
    wr(pist_pkg::IDX_MON_MASK, 32'hffff_ffff);
    rd_chk("mask", pist_pkg::IDX_MON_MASK, 32'hff);
    wr(pist_pkg::IDX_MON_MASK, 32'h0000_0042);
    wr(pist_pkg::IDX_TOP_SUM, 32'hff);
    wr(pist_pkg::IDX_REG_SUM, 32'hff);
    rd_chk("top", pist_pkg::IDX_TOP_SUM, 32'h0);
    rd_chk("regsum", pist_pkg::IDX_REG_SUM, 32'h0);
    // Nonvolatile default loads only bits 5:3
    @(posedge CLOCK);
    NVM_MON_MASK <= 8'hff;
    NVM_LOAD <= 1'b1;
    @(posedge CLOCK);
    NVM_LOAD <= 1'b0;
    rd_chk("mask", pist_pkg::IDX_MON_MASK, 32'h7a);
    // Monitor masks: masked event keeps irq low, unmask raises it
    for (int i = 0; i < 3; i++) begin
      wr(pist_pkg::IDX_MON_MASK, 32'h38);
      @(posedge CLOCK);
      MON_EVENT <= pist_pkg::pist_mon_event_t'(3'h1 << i);
      @(posedge CLOCK);
      MON_EVENT <= '0;
      rd_chk("monstat", pist_pkg::IDX_MON_STAT, 32'h08 << i);
      irq_chk(1'b0);
      wr(pist_pkg::IDX_MON_MASK, ~(32'h08 << i) & 32'h38);
      rd_chk("mask", pist_pkg::IDX_MON_MASK, ~(32'h08 << i) & 32'h38);
      irq_chk(1'b1);
      wr(pist_pkg::IDX_MON_STAT, 32'h08 << i);
      rd_chk("monstat", pist_pkg::IDX_MON_STAT, 32'h0);
      irq_chk(1'b0);
    end
    // Outside leaf registers drive top summary bits 7:1
    for (int j = 0; j < 7; j++) begin
      @(posedge CLOCK);
      LEAF_PENDING <= pist_pkg::pist_leaf_pending_t'(7'h1 << j);
      rd_chk("top", pist_pkg::IDX_TOP_SUM, 32'h02 << j);
      irq_chk(1'b1);
      @(posedge CLOCK);
      LEAF_PENDING <= '0;
      rd_chk("top", pist_pkg::IDX_TOP_SUM, 32'h0);
      irq_chk(1'b0);
    end
    // Regulator leaves: latch, partial clear, full clear
    for (int k = 0; k < 2; k++) begin
      @(posedge CLOCK);
      REG_EVENT <= pist_pkg::pist_reg_event_t'(16'h0081 << (8 * k));
      @(posedge CLOCK);
      REG_EVENT <= '0;
      rd_chk("regev", pist_pkg::IDX_REG12_EV + 8'(k), 32'h81);
      rd_chk("regsum", pist_pkg::IDX_REG_SUM, 32'h1 << k);
      rd_chk("top", pist_pkg::IDX_TOP_SUM, 32'h1);
      irq_chk(1'b1);
      wr(pist_pkg::IDX_REG12_EV + 8'(k), 32'h01);
      rd_chk("regev", pist_pkg::IDX_REG12_EV + 8'(k), 32'h80);
      rd_chk("regsum", pist_pkg::IDX_REG_SUM, 32'h1 << k);
      wr(pist_pkg::IDX_REG12_EV + 8'(k), 32'h80);
      rd_chk("regsum", pist_pkg::IDX_REG_SUM, 32'h0);
      rd_chk("top", pist_pkg::IDX_TOP_SUM, 32'h0);
      irq_chk(1'b0);
    end
    give_verdict();
  end
endmodule

`default_nettype wire
